/* File: logic/dds_nco_phase_sine_core.sv */
// dds core: nco, phase offset, sine table, avalon register slave and write fifo
`timescale 1ns/10ps
`include "dds_map.svh"

module dds_word_fifo #(
  parameter int WIDTH = 31,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready_o = (count_q != (AW+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end
    else
    begin
      // depth is a power of two, so pointers wrap by themselves
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module dds_nco_phase_sine_core #(
  parameter int ACC_WIDTH = 28,
  parameter int PHASE_WIDTH = 12,
  parameter int DAC_WIDTH = 10,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic freq_word_select_pin_i,
  input wire logic phase_offset_select_pin_i,
  input wire logic comparator_i,
  output logic [DAC_WIDTH-1:0] dac_code_o,
  output logic sign_bit_o
);
  localparam int ENTRY_W = 3 + ACC_WIDTH;

  logic [`CTL_WIDTH-1:0] control_q;
  logic [ACC_WIDTH-1:0] frequency_word_a_q;
  logic [ACC_WIDTH-1:0] frequency_word_b_q;
  logic [PHASE_WIDTH-1:0] phase_offset_a_q;
  logic [PHASE_WIDTH-1:0] phase_offset_b_q;
  logic ack_q;
  logic waitrequest_q;
  logic [31:0] readdata_q;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [ENTRY_W-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [ENTRY_W-1:0] fifo_out_data;
  dds_pkg::word_index_type wr_index;
  logic word_write;
  logic take;
  logic core_reset;
  logic freq_word_select_bit_q;
  logic psel_q;
  logic [ACC_WIDTH-1:0] inc_q;
  logic [PHASE_WIDTH-1:0] off_q;
  logic [PHASE_WIDTH-1:0] off_d1_q;
  logic [ACC_WIDTH-1:0] acc_q;
  logic [PHASE_WIDTH-1:0] addr_q [`ADDR_DELAY+1];
  logic [DAC_WIDTH-1:0] code_q;
  logic msb_q;
  logic [DAC_WIDTH-1:0] dac_q;
  logic sign_q;
  logic freq_word_select_bit_d;
  logic psel_d;
  dds_pkg::wave_type wave;

  assign core_reset = control_q[`CTL_CORE_RESET];
  assign wave = control_q[`CTL_WAVE_MODE] ? dds_pkg::wave_bypass : dds_pkg::wave_sine;

  ////////////////////////////////////////////////////////////////////////////////
  // avalon slave: one answer per request, waitrequest low for one cycle

  always_comb
  begin
    case (address_i)
      `OFS_FREQ_A: wr_index = dds_pkg::word_freq_a;
      `OFS_FREQ_B: wr_index = dds_pkg::word_freq_b;
      `OFS_PHASE_A: wr_index = dds_pkg::word_phase_a;
      `OFS_PHASE_B: wr_index = dds_pkg::word_phase_b;
      default: wr_index = dds_pkg::word_none;
    endcase
  end

  // only full-word writes reach the word registers, so no half word leaks in
  assign word_write = write_i && !ack_q && (wr_index != dds_pkg::word_none)
                      && (byteenable_i == 4'hF);
  assign fifo_in_valid = word_write;
  assign fifo_in_data = {wr_index, writedata_i[ACC_WIDTH-1:0]};
  // a word write waits for fifo space; everything else is taken at once
  assign take = (read_i || write_i) && !ack_q && (!word_write || fifo_in_ready);

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      waitrequest_q <= 1'b1;
      readdata_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= take;
      waitrequest_q <= !take;
      if (take && read_i)
      begin
        case (address_i)
          `OFS_CONTROL: readdata_q <= 32'(control_q);
          `OFS_FREQ_A: readdata_q <= 32'(frequency_word_a_q);
          `OFS_FREQ_B: readdata_q <= 32'(frequency_word_b_q);
          `OFS_PHASE_A: readdata_q <= 32'(phase_offset_a_q);
          `OFS_PHASE_B: readdata_q <= 32'(phase_offset_b_q);
          `OFS_STATUS: readdata_q <= {4'h0, addr_q[0], 12'h000, psel_q, freq_word_select_bit_q,
                                      !fifo_in_ready, !fifo_out_valid};
          default: readdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign readdata_o = readdata_q;
  assign waitrequest_o = waitrequest_q;

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      control_q <= `RST_CONTROL;
    end
    else if (take && write_i && address_i == `OFS_CONTROL && byteenable_i[0])
    begin
      control_q <= writedata_i[`CTL_WIDTH-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // word writes queue here; hold lets software release several words, one per clock

  dds_word_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) word_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  assign fifo_out_ready = !control_q[`CTL_WORD_HOLD];

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      frequency_word_a_q <= `RST_FREQ;
      frequency_word_b_q <= `RST_FREQ;
      phase_offset_a_q <= `RST_PHASE;
      phase_offset_b_q <= `RST_PHASE;
    end
    else if (fifo_out_valid && fifo_out_ready)
    begin
      // whole word in one edge
      case (dds_pkg::word_index_type'(fifo_out_data[ENTRY_W-1 -: 3]))
        dds_pkg::word_freq_a: frequency_word_a_q <= fifo_out_data[ACC_WIDTH-1:0];
        dds_pkg::word_freq_b: frequency_word_b_q <= fifo_out_data[ACC_WIDTH-1:0];
        dds_pkg::word_phase_a: phase_offset_a_q <= fifo_out_data[PHASE_WIDTH-1:0];
        dds_pkg::word_phase_b: phase_offset_b_q <= fifo_out_data[PHASE_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // nco: stage 1 select, 2 word, 3 accumulate, 4 offset add and truncate

  assign freq_word_select_bit_d = control_q[`CTL_PIN_SEL_EN] ? freq_word_select_pin_i
                                               : control_q[`CTL_FREQ_SEL];
  assign psel_d = control_q[`CTL_PIN_SEL_EN] ? phase_offset_select_pin_i
                                               : control_q[`CTL_PHASE_SEL];

  // only the increment changes on a switch; acc keeps running
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      freq_word_select_bit_q <= 1'b0;
      psel_q <= 1'b0;
      inc_q <= '0;
      off_q <= '0;
      off_d1_q <= '0;
      acc_q <= '0;
      addr_q[0] <= '0;
    end
    else if (core_reset)
    begin
      freq_word_select_bit_q <= 1'b0;
      psel_q <= 1'b0;
      inc_q <= '0;
      off_q <= '0;
      off_d1_q <= '0;
      acc_q <= '0;
      addr_q[0] <= '0;
    end
    else
    begin
      freq_word_select_bit_q <= freq_word_select_bit_d;
      psel_q <= psel_d;
      inc_q <= freq_word_select_bit_q ? frequency_word_b_q : frequency_word_a_q;
      off_q <= psel_q ? phase_offset_b_q : phase_offset_a_q;
      off_d1_q <= off_q;
      acc_q <= acc_q + inc_q; // natural wrap, f = word * fclk / 2^28
      // offset lands on the top bits, lower bits dropped
      addr_q[0] <= acc_q[ACC_WIDTH-1 -: PHASE_WIDTH] + off_d1_q;
    end
  end

  // padding stages so a select pin change reaches the dac in eight edges
  for (genvar i = 1; i <= `ADDR_DELAY; i++)
  begin : g_delay
    always_ff @(posedge clock_i or posedge rst_i)
    begin
      if (rst_i)
      begin
        addr_q[i] <= '0;
      end
      else if (core_reset)
      begin
        addr_q[i] <= '0;
      end
      else
      begin
        addr_q[i] <= addr_q[i-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sine table: parabolic half-wave, offset binary, phase 0 gives midscale

  function automatic logic [DAC_WIDTH-1:0] sine_code(input logic [PHASE_WIDTH-1:0] ph);
    logic [PHASE_WIDTH-2:0] p;
    logic [PHASE_WIDTH-1:0] q;
    logic [2*PHASE_WIDTH-1:0] prod;
    logic [DAC_WIDTH-1:0] amp;
    p = ph[PHASE_WIDTH-2:0];
    q = PHASE_WIDTH'(1 << (PHASE_WIDTH-1)) - PHASE_WIDTH'(p);
    prod = (2*PHASE_WIDTH)'(p) * (2*PHASE_WIDTH)'(q);
    // peak of the product is 2^20, so a shift by 11 gives 0..512; clip to 511
    amp = (prod[2*PHASE_WIDTH-1:PHASE_WIDTH-1] > (2*PHASE_WIDTH-PHASE_WIDTH+1)'(511))
          ? DAC_WIDTH'(511) : prod[PHASE_WIDTH-1 +: DAC_WIDTH];
    sine_code = ph[PHASE_WIDTH-1] ? `DAC_MIDSCALE - amp : `DAC_MIDSCALE + amp;
  endfunction

  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      code_q <= `DAC_MIDSCALE;
      msb_q <= 1'b0;
      dac_q <= `DAC_MIDSCALE;
    end
    else if (core_reset)
    begin
      code_q <= `DAC_MIDSCALE;
      msb_q <= 1'b0;
      dac_q <= `DAC_MIDSCALE;
    end
    else
    begin
      // table in path only in sine mode
      if (wave == dds_pkg::wave_sine)
      begin
        code_q <= sine_code(addr_q[`ADDR_DELAY]);
      end
      else
      begin
        code_q <= addr_q[`ADDR_DELAY][PHASE_WIDTH-1 -: DAC_WIDTH];
      end
      msb_q <= addr_q[`ADDR_DELAY][PHASE_WIDTH-1];
      dac_q <= code_q;
    end
  end

  // comparator input is taken as synchronous; pin low while disabled
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sign_q <= 1'b0;
    end
    else if (control_q[`CTL_LOGIC_OUT_EN])
    begin
      sign_q <= control_q[`CTL_SIGN_SRC] ? comparator_i : msb_q;
    end
    else
    begin
      sign_q <= 1'b0;
    end
  end

  assign dac_code_o = dac_q;
  assign sign_bit_o = sign_q;
endmodule

/* File: logic/dds_map.svh */
// register map, field positions, reset values and pipeline counts of the dds core
// Function
// - 28-bit accumulator adds selected word, wraps
// - output frequency is word times clock over 2^28
// - increment from one of two words
// - switching words leaves accumulator untouched
// - add selected 12-bit offset to accumulator top
// - truncate phase sum to top 12 bits
// - sine table maps 12-bit phase to 10-bit code
// - wave mode bit alone decides sine path
// - offset chosen by pin or control bit
// - select pin change reaches output after eight cycles
// - core reset zeroes phase path, sets dac to midscale, keeps registers
// - logic pin shows comparator or oscillator msb
`ifndef DDS_MAP_SVH
`define DDS_MAP_SVH

`define OFS_CONTROL 5'h00
`define OFS_FREQ_A 5'h04
`define OFS_FREQ_B 5'h08
`define OFS_PHASE_A 5'h0C
`define OFS_PHASE_B 5'h10
`define OFS_STATUS 5'h14

`define CTL_FREQ_SEL 0
`define CTL_PHASE_SEL 1
`define CTL_PIN_SEL_EN 2
`define CTL_CORE_RESET 3
`define CTL_WAVE_MODE 4
`define CTL_LOGIC_OUT_EN 5
`define CTL_SIGN_SRC 6
`define CTL_WORD_HOLD 7
`define CTL_WIDTH 8

`define RST_CONTROL 8'h00
`define RST_FREQ 28'h0000000
`define RST_PHASE 12'h000
`define DAC_MIDSCALE 10'h200

`define ADDR_DELAY 2
`define FIFO_DEPTH 8

`endif

/* File: logic/dds_pkg.sv */
// types shared by the dds core
package dds_pkg;
  typedef enum logic {wave_sine, wave_bypass} wave_type;
  typedef enum logic [2:0] {word_freq_a, word_freq_b, word_phase_a, word_phase_b, word_none}
    word_index_type;
endpackage

/* File: dv/dac_load_model.sv */
// behavioural model of the dac and logic pin load
`timescale 1ns/10ps
module dac_load_model (
  input wire logic clock_i,
  input wire logic [9:0] code_i,
  input wire logic level_i,
  output logic [9:0] held_code_o,
  output logic held_level_o
);
  // the converter latches each code once per clock, like a real dac input register
  always_ff @(posedge clock_i)
  begin
    held_code_o <= code_i;
    held_level_o <= level_i;
  end
endmodule

/* File: dv/dds_core_props.sv */
// concurrent checks on the ports of the dds core
`timescale 1ns/10ps
module dds_core_props #(
  parameter int DAC_WIDTH = 10
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o,
  input wire logic [DAC_WIDTH-1:0] dac_code_o,
  input wire logic sign_bit_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_read_taken;
    read_i && waitrequest_o;
  endsequence
  sequence s_core_clear;
    write_i && waitrequest_o && address_i == 5'h00 && byteenable_i[0] && writedata_i[3];
  endsequence
  a_ack_one_cycle: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_ack_needs_req: assert property ($fell(waitrequest_o) |-> $past(read_i || write_i))
    else $error("answer without a request");
  a_read_answer: assert property (s_read_taken |=> !waitrequest_o)
    else $error("read not answered in the next cycle");
  a_ctl_write_ack: assert property (s_core_clear |=> !waitrequest_o)
    else $error("control write not answered in the next cycle");
  a_unmapped_zero: assert property (s_read_taken ##0 address_i == 5'h18 |=> readdata_o == 32'h0)
    else $error("unmapped read returned nonzero");
  a_rdata_hold: assert property (!(read_i && waitrequest_o) |=> $stable(readdata_o))
    else $error("read data moved without a read");
  a_idle_wait: assert property (!read_i && !write_i |=> waitrequest_o)
    else $error("waitrequest low with no request");
  a_reset_midscale: assert property ($fell(rst_i) |-> dac_code_o == 10'h200)
    else $error("dac not midscale after reset");
  a_core_midscale: assert property (s_core_clear |-> ##[1:3] dac_code_o == 10'h200)
    else $error("dac not midscale after core clear");
endmodule
bind dds_nco_phase_sine_core dds_core_props #(.DAC_WIDTH(DAC_WIDTH)) i_dds_core_props (
  .clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .dac_code_o(dac_code_o),
  .sign_bit_o(sign_bit_o));

/* File: dv/dds_nco_phase_sine_core_test.sv */
// self-checking bench of the dds core
`timescale 1ns/10ps
`include "dds_map.svh"
module dds_nco_phase_sine_core_test;
  logic clock_i, rst_i, read_i, write_i, fpin, ppin, cmp, wr, sign, held_sign;
  logic [4:0] address;
  logic [31:0] wdata, rdata, got;
  logic [3:0] be;
  logic [9:0] dac, held, prev;
  int n_mismatch = 0;
  int num_checks = 0;
  dds_nco_phase_sine_core i_dds_nco_phase_sine_core (.clock_i(clock_i), .rst_i(rst_i),
    .address_i(address), .read_i(read_i), .write_i(write_i), .writedata_i(wdata),
    .byteenable_i(be), .readdata_o(rdata), .waitrequest_o(wr),
    .freq_word_select_pin_i(fpin), .phase_offset_select_pin_i(ppin),
    .comparator_i(cmp), .dac_code_o(dac), .sign_bit_o(sign));
  dac_load_model i_dac_load_model (.clock_i(clock_i), .code_i(dac), .level_i(sign),
    .held_code_o(held), .held_level_o(held_sign));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  // values are read right at the edge, before the design's updates land
  task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d,
    input logic [3:0] b);
    address <= a;
    wdata <= d;
    be <= b;
    read_i <= rd;
    write_i <= !rd;
    @(posedge clock_i);
    while (wr !== 1'b0) @(posedge clock_i);
    got = rdata;
    read_i <= 1'b0;
    write_i <= 1'b0;
    // one idle edge so a following call never reassigns the strobes in this step
    @(posedge clock_i);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(dac, 32'h200);
    check(sign, 32'h0);
    bus(1'b1, `OFS_CONTROL, 32'h0, 4'hF);
    check(got, 32'h0);
    bus(1'b1, `OFS_STATUS, 32'h0, 4'hF);
    check(got[1:0], 32'h1);
    bus(1'b1, 5'h18, 32'h0, 4'hF);
    check(got, 32'h0);
  endtask
  // bypass mode shows phase[11:2], so the step per clock is the word over 2^18
  task automatic t_ramp();
    bus(1'b0, `OFS_CONTROL, 32'h10, 4'hF);
    bus(1'b0, `OFS_FREQ_A, 32'h4000000, 4'hF);
    bus(1'b0, `OFS_FREQ_B, 32'h2000000, 4'hF);
    tick(12);
    for (int i = 0; i < 4; i++)
    begin
      prev = dac;
      tick(1);
      check(10'(dac - prev), 32'h100);
    end
    bus(1'b0, `OFS_CONTROL, 32'h11, 4'hF);
    tick(12);
    for (int i = 0; i < 4; i++)
    begin
      prev = dac;
      tick(1);
      check(10'(dac - prev), 32'h80);
    end
  endtask
  task automatic t_offset();
    bus(1'b0, `OFS_FREQ_A, 32'h0, 4'hF);
    bus(1'b0, `OFS_CONTROL, 32'h18, 4'hF);
    tick(3);
    check(dac, 32'h200);
    bus(1'b0, `OFS_PHASE_A, 32'hC00, 4'hF);
    bus(1'b0, `OFS_PHASE_B, 32'h400, 4'hF);
    bus(1'b0, `OFS_CONTROL, 32'h12, 4'hF);
    tick(12);
    check(dac, 32'h100);
    check(held, 32'h100);
    bus(1'b0, `OFS_CONTROL, 32'h10, 4'hF);
    bus(1'b0, `OFS_PHASE_A, 32'h004, 4'h3);
    tick(12);
    check(dac, 32'h300);
  endtask
  task automatic t_pins();
    bus(1'b0, `OFS_CONTROL, 32'h14, 4'hF);
    tick(12);
    ppin <= 1'b1;
    tick(7);
    check(dac, 32'h300);
    tick(2);
    check(dac, 32'h100);
    ppin <= 1'b0;
    tick(12);
    fpin <= 1'b1;
    tick(12);
    prev = dac;
    tick(1);
    check(10'(dac - prev), 32'h80);
    fpin <= 1'b0;
    bus(1'b0, `OFS_CONTROL, 32'h1C, 4'hF);
    tick(3);
    check(dac, 32'h200);
  endtask
  task automatic t_sign();
    bus(1'b0, `OFS_CONTROL, 32'h70, 4'hF);
    cmp <= 1'b1;
    tick(3);
    check(sign, 32'h1);
    check(held_sign, 32'h1);
    cmp <= 1'b0;
    tick(3);
    check(sign, 32'h0);
    bus(1'b0, `OFS_CONTROL, 32'h30, 4'hF);
    tick(12);
    check(sign, 32'h1);
    cmp <= 1'b1;
    bus(1'b0, `OFS_CONTROL, 32'h10, 4'hF);
    tick(3);
    check(sign, 32'h0);
  endtask
  // hold keeps words queued until it is cleared; eight writes make the fifo report full
  task automatic t_fifo();
    bus(1'b0, `OFS_CONTROL, 32'h90, 4'hF);
    for (int i = 0; i < `FIFO_DEPTH; i++)
      bus(1'b0, `OFS_FREQ_B, 32'h1 + i, 4'hF);
    bus(1'b1, `OFS_STATUS, 32'h0, 4'hF);
    check(got[1:0], 32'h2);
    bus(1'b0, `OFS_CONTROL, 32'h10, 4'hF);
    tick(12);
    bus(1'b1, `OFS_STATUS, 32'h0, 4'hF);
    check(got[1:0], 32'h1);
    bus(1'b1, `OFS_FREQ_B, 32'h0, 4'hF);
    check(got, 32'h8);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  initial
  begin
    tick(5000);
    n_mismatch++;
    close_out();
  end
  initial
  begin
    {read_i, write_i, fpin, ppin, cmp} = 5'h00;
    address = 5'h00;
    wdata = 32'h0;
    be = 4'hF;
    rst_i = 1'b1;
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    t_reset();
    t_ramp();
    t_offset();
    t_pins();
    t_sign();
    t_fifo();
    close_out();
  end
endmodule
